/* File: src/itiu_top.sv */
// Purpose: three-channel 16-bit interval timer with timer and heartbeat interrupts
// Assumes: one-cycle bus_rd/bus_wr strobes, pins are asynchronous to clk
// Notes:   binary counting only; a count of zero acts as 65536 in modes 0, 1 and 5
//
// Function
// [RULE_01] mode 0: output low on count write, high after N+1 ticks
// [RULE_02] mode 0: count written mid-run loads on next tick, retriggers
// [RULE_03] mode 1: gate fall loads counter, output low N ticks
// [RULE_04] mode 1: each trigger restarts pulse; new count waits for trigger
// [RULE_05] mode 3: square wave period N, high (N+1)/2, low (N-1)/2
// [RULE_06] channel 0 mode 3: gate low reloads original count, restarts
// [RULE_07] mode 5: gate fall, after N+1 ticks output low one tick
// [RULE_08] software uses mode 0 on channels 1,2 N>=3, mode 3 N>=5
// [RULE_09] modes 1 and 5 only on channel 0, clock below 3 MHz
// [RULE_10] status-read byte freezes state; next data read returns it
// [RULE_11] rising output of channels 0 and 2 always sets status bit
// [RULE_12] channels 1,2 tick at 10 MHz; channel 0 from external clock
// [RULE_13] gates of channels 1 and 2 tied active, no triggers
// [RULE_14] channel 0 gate synchronised, each fall gives one-tick pulse
// [RULE_15] combined timer request drives system and peripheral controllers
// [RULE_16] request is (bit0 and bit4) or (bit1 and bit5)
// [RULE_17] status reads show channel 2 enable bit 5, channel 0 bit 4
// [RULE_18] read at 0x14 clears bits 1:0; read at 0x10 changes nothing
// [RULE_19] write 0x10 toggles bit 4, write 0x14 toggles bit 5
// [RULE_20] channel 1 output goes raw to system controller input 3
// [RULE_21] channel 1,2 outputs driven active low; channel 0 inputs active low
// [RULE_22] heartbeat rising edge sets latched peripheral request input 1
// [RULE_23] heartbeat request cleared only by write to clear register
// [RULE_24] control byte: select 7:6, access 5:4, mode 3:1, bcd 0
// [RULE_25] 16-bit count via byte register, low byte then high byte
// [RULE_26] control at 0x0C, data registers at 0x00, 0x04, 0x08
// [RULE_27] reset clears expiry bits and enables, request deasserted
`timescale 1ns/1ps
module itiu_top
	import itiu_pkg::*;
#(
	parameter int DIV = CH_DIV
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	input  wire logic [15:0] bus_addr,
	input  wire logic        bus_rd,
	input  wire logic        bus_wr,
	input  wire logic [7:0]  bus_wdata,
	output logic      [7:0]  bus_rdata,
	input  wire logic        ext_count_clock_n,
	input  wire logic        ext_trigger_gate_n,
	input  wire logic        heartbeat_wave,
	output logic             channel1_ext_out_n,
	output logic             channel2_ext_out_n,
	output logic             timer_irq_line,
	output logic             timer_irq_periph,
	output logic             channel1_sys_irq,
	output logic             heartbeat_irq_input
);
	// pin synchronisers: 0 count clock, 1 gate, 2 heartbeat
	logic [2:0]  sync1_ff, sync2_ff, sync3_ff, lvl_ff;
	logic [2:0]  pin_fall, pin_rise;
	logic [$clog2(DIV+1)-1:0] pre_ff;
	logic [NUM_CH-1:0] tick;
	logic        gate_pulse;

	logic [2:0]  mode_ff   [NUM_CH];
	logic [1:0]  acc_ff    [NUM_CH];
	logic        bcd_ff    [NUM_CH];
	logic [15:0] reload_ff [NUM_CH];
	logic [15:0] cnt_ff    [NUM_CH];
	logic [15:0] latch_ff  [NUM_CH];
	logic [7:0]  stat_ff   [NUM_CH];
	logic [NUM_CH-1:0] out_ff, run_ff, ld_pend_ff, wr_hi_ff, rd_hi_ff;
	logic [NUM_CH-1:0] st_lat_ff, cl_lat_ff;
	logic        trig_pend_ff;
	logic [1:0]  exp_ff, en_ff;
	logic [1:0]  nxt_exp, nxt_en;
	logic        out0_d_ff, out2_d_ff;
	logic        hb_ff;
	logic        nxt_hb;

	logic        wr_ctl, rd_peek, rd_clr, wr_peek, wr_clr, wr_hb;
	logic [NUM_CH-1:0] wr_dat, rd_dat;
	logic [1:0]  ctl_sel;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		return a == (TIMER_BLOCK_BASE + ofs);
	endfunction

	function automatic logic [15:0] half_hi(input logic [15:0] n);
		return 16'((17'(n) + 17'h00001) >> 1);
	endfunction

	// address decode [RULE_26]
	always_comb begin
		wr_ctl  = bus_wr && hit(bus_addr, OFS_CONTROL);
		wr_peek = bus_wr && hit(bus_addr, OFS_STATUS_PEEK);
		wr_clr  = bus_wr && hit(bus_addr, OFS_STATUS_CLEAR);
		rd_peek = bus_rd && hit(bus_addr, OFS_STATUS_PEEK);
		rd_clr  = bus_rd && hit(bus_addr, OFS_STATUS_CLEAR);
		wr_hb   = bus_wr && (bus_addr == HEARTBEAT_CLEAR);
		wr_dat[0] = bus_wr && hit(bus_addr, OFS_CH0_DATA);
		wr_dat[1] = bus_wr && hit(bus_addr, OFS_CH1_DATA);
		wr_dat[2] = bus_wr && hit(bus_addr, OFS_CH2_DATA);
		rd_dat[0] = bus_rd && hit(bus_addr, OFS_CH0_DATA);
		rd_dat[1] = bus_rd && hit(bus_addr, OFS_CH1_DATA);
		rd_dat[2] = bus_rd && hit(bus_addr, OFS_CH2_DATA);
		ctl_sel = bus_wdata[CTL_SEL_HI:CTL_SEL_LO];
	end

	// three-stage synchronisers; a change counts once stages two and three agree
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_ff <= 3'h7;
			sync2_ff <= 3'h7;
			sync3_ff <= 3'h7;
			lvl_ff   <= 3'h7;
		end else if (ce) begin
			sync1_ff <= {heartbeat_wave, ext_trigger_gate_n, ext_count_clock_n};
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			for (int k = 0; k < 3; k++) begin
				if (sync2_ff[k] == sync3_ff[k])
					lvl_ff[k] <= sync3_ff[k];
			end
		end
	end

	always_comb begin
		for (int k = 0; k < 3; k++) begin
			pin_fall[k] = (sync2_ff[k] == sync3_ff[k]) && !sync3_ff[k] && lvl_ff[k];
			pin_rise[k] = (sync2_ff[k] == sync3_ff[k]) && sync3_ff[k] && !lvl_ff[k];
		end
		// active-low clock: asserting edge is the fall [RULE_21]
		tick[0]    = pin_fall[0]; // [RULE_12]
		gate_pulse = pin_fall[1]; // single-cycle pulse per gate fall [RULE_14]
		tick[1]    = (pre_ff == ($bits(pre_ff))'(DIV - 1)); // [RULE_12]
		tick[2]    = tick[1];
	end

	// 10 MHz tick for channels 1 and 2
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			pre_ff <= '0;
		else if (ce)
			pre_ff <= tick[1] ? '0 : pre_ff + 1'b1;
	end

	// channel 0 trigger held until its next clock tick or a channel 0 control write; channels 1,2 never trigger [RULE_13]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			trig_pend_ff <= 1'b0;
		end else if (ce) begin
			if (gate_pulse)
				trig_pend_ff <= 1'b1;
			else if (tick[0] || (wr_ctl && ctl_sel == 2'b00))
				trig_pend_ff <= 1'b0;
		end
	end

	// counting engines
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				mode_ff[i]   <= MODE_RESET;
				acc_ff[i]    <= ACC_RESET;
				bcd_ff[i]    <= 1'b0;
				reload_ff[i] <= COUNT_RESET;
				cnt_ff[i]    <= COUNT_RESET;
			end
			out_ff     <= '1;
			run_ff     <= '0;
			ld_pend_ff <= '0;
			wr_hi_ff   <= '0;
		end else if (ce) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (tick[i]) begin
					case (mode_ff[i])
						MODE_ONESHOT_SW: begin
							if (ld_pend_ff[i]) begin
								cnt_ff[i]     <= reload_ff[i]; // [RULE_02]
								ld_pend_ff[i] <= 1'b0;
								run_ff[i]     <= 1'b1;
							end else if (run_ff[i]) begin
								cnt_ff[i] <= cnt_ff[i] - 16'h0001;
								if (cnt_ff[i] == 16'h0001) begin
									out_ff[i] <= 1'b1; // load tick plus N [RULE_01]
									run_ff[i] <= 1'b0;
								end
							end
						end
						MODE_ONESHOT_HW: begin
							if (i == 0 && trig_pend_ff) begin
								cnt_ff[i] <= reload_ff[i]; // [RULE_03] [RULE_04]
								out_ff[i] <= 1'b0;
								run_ff[i] <= 1'b1;
							end else if (run_ff[i]) begin
								cnt_ff[i] <= cnt_ff[i] - 16'h0001;
								if (cnt_ff[i] == 16'h0001) begin
									out_ff[i] <= 1'b1; // [RULE_03]
									run_ff[i] <= 1'b0;
								end
							end
						end
						MODE_SQUARE: begin
							if (ld_pend_ff[i] || (i == 0 && trig_pend_ff)) begin
								cnt_ff[i]     <= half_hi(reload_ff[i]); // [RULE_06]
								out_ff[i]     <= 1'b1;
								run_ff[i]     <= 1'b1;
								ld_pend_ff[i] <= 1'b0;
							end else if (run_ff[i]) begin
								if (cnt_ff[i] <= 16'h0001) begin
									out_ff[i] <= ~out_ff[i];
									// odd N: high (N+1)/2, low (N-1)/2 [RULE_05]
									cnt_ff[i] <= out_ff[i] ? (reload_ff[i] >> 1)
										: half_hi(reload_ff[i]);
								end else begin
									cnt_ff[i] <= cnt_ff[i] - 16'h0001;
								end
							end
						end
						MODE_STROBE_HW: begin
							if (i == 0 && trig_pend_ff) begin
								cnt_ff[i] <= reload_ff[i]; // retrigger restarts delay [RULE_07]
								out_ff[i] <= 1'b1;
								run_ff[i] <= 1'b1;
							end else if (run_ff[i]) begin
								cnt_ff[i] <= cnt_ff[i] - 16'h0001;
								if (cnt_ff[i] == 16'h0001) begin
									out_ff[i] <= 1'b0; // [RULE_07]
									run_ff[i] <= 1'b0;
								end
							end else if (!out_ff[i]) begin
								out_ff[i] <= 1'b1;
							end
						end
						default: begin
							// modes 2, 4, 6 and 7 are not supported; channel holds its state
							out_ff[i] <= out_ff[i];
						end
					endcase
				end
				// bus writes placed last so they win over a same-cycle tick
				if (wr_ctl && ctl_sel == 2'(i)
						&& bus_wdata[CTL_ACC_HI:CTL_ACC_LO] != ACC_LATCH) begin
					mode_ff[i]    <= bus_wdata[CTL_MODE_HI:CTL_MODE_LO]; // [RULE_24]
					acc_ff[i]     <= bus_wdata[CTL_ACC_HI:CTL_ACC_LO];
					bcd_ff[i]     <= bus_wdata[CTL_BCD];
					wr_hi_ff[i]   <= 1'b0;
					run_ff[i]     <= 1'b0;
					ld_pend_ff[i] <= 1'b0;
					out_ff[i]     <= 1'b1; // every mode idles high until armed [RULE_01]
				end else if (wr_dat[i]) begin
					case (acc_ff[i]) // [RULE_25]
						ACC_LSB: reload_ff[i][7:0]  <= bus_wdata;
						ACC_MSB: reload_ff[i][15:8] <= bus_wdata;
						default: begin
							if (wr_hi_ff[i])
								reload_ff[i][15:8] <= bus_wdata;
							else
								reload_ff[i][7:0] <= bus_wdata;
							wr_hi_ff[i] <= ~wr_hi_ff[i];
						end
					endcase
					// count complete on single byte or on the high byte
					if (acc_ff[i] != ACC_BOTH || wr_hi_ff[i]) begin
						if (mode_ff[i] == MODE_ONESHOT_SW) begin
							ld_pend_ff[i] <= 1'b1; // [RULE_02]
							out_ff[i]     <= 1'b0; // [RULE_01]
						end else if (mode_ff[i] == MODE_SQUARE && !run_ff[i]) begin
							ld_pend_ff[i] <= 1'b1;
						end
						// modes 1 and 5 keep the new count until a trigger [RULE_04]
					end
				end
			end
		end
	end

	// read-back: freeze status and count for the next data reads [RULE_10]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_lat_ff <= '0;
			cl_lat_ff <= '0;
			rd_hi_ff  <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				stat_ff[i]  <= 8'h00;
				latch_ff[i] <= COUNT_RESET;
			end
		end else if (ce) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (rd_dat[i]) begin
					if (st_lat_ff[i]) begin
						st_lat_ff[i] <= 1'b0;
					end else begin
						if (acc_ff[i] == ACC_BOTH)
							rd_hi_ff[i] <= ~rd_hi_ff[i];
						if (acc_ff[i] != ACC_BOTH || rd_hi_ff[i])
							cl_lat_ff[i] <= 1'b0;
					end
				end
				if (wr_ctl && ctl_sel == SEL_STATUS_READ && bus_wdata[CTL_MODE_LO + i]) begin
					if (!bus_wdata[RB_NO_STATUS] && !st_lat_ff[i]) begin
						st_lat_ff[i] <= 1'b1;
						stat_ff[i]   <= {out_ff[i], 1'b0, acc_ff[i], mode_ff[i], bcd_ff[i]};
					end
					if (!bus_wdata[RB_NO_COUNT] && !cl_lat_ff[i]) begin
						cl_lat_ff[i] <= 1'b1;
						latch_ff[i]  <= cnt_ff[i];
					end
				end else if (wr_ctl && ctl_sel == 2'(i)) begin
					if (bus_wdata[CTL_ACC_HI:CTL_ACC_LO] == ACC_LATCH) begin
						if (!cl_lat_ff[i]) begin
							cl_lat_ff[i] <= 1'b1;
							latch_ff[i]  <= cnt_ff[i];
						end
					end else begin
						rd_hi_ff[i]  <= 1'b0;
						st_lat_ff[i] <= 1'b0;
						cl_lat_ff[i] <= 1'b0;
					end
				end
			end
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_rdata <= 8'h00;
		end else if (ce && bus_rd) begin
			bus_rdata <= 8'h00;
			if (rd_peek || rd_clr)
				bus_rdata <= {2'b00, en_ff, 2'b00, exp_ff}; // [RULE_17]
			for (int i = 0; i < NUM_CH; i++) begin
				if (rd_dat[i]) begin
					if (st_lat_ff[i])
						bus_rdata <= stat_ff[i];
					else if (acc_ff[i] == ACC_MSB || (acc_ff[i] == ACC_BOTH && rd_hi_ff[i]))
						bus_rdata <= cl_lat_ff[i] ? latch_ff[i][15:8] : cnt_ff[i][15:8];
					else
						bus_rdata <= cl_lat_ff[i] ? latch_ff[i][7:0] : cnt_ff[i][7:0];
				end
			end
		end
	end

	// expiry status and enables; a new expiry wins over a clearing read
	always_comb begin
		nxt_exp = exp_ff;
		nxt_en  = en_ff;
		if (rd_clr)
			nxt_exp = 2'b00; // [RULE_18]
		if (out_ff[0] && !out0_d_ff)
			nxt_exp[ST_EXP0] = 1'b1; // [RULE_11]
		if (out_ff[2] && !out2_d_ff)
			nxt_exp[ST_EXP2] = 1'b1; // [RULE_11]
		if (wr_peek)
			nxt_en[0] = ~en_ff[0]; // [RULE_19]
		if (wr_clr)
			nxt_en[1] = ~en_ff[1]; // [RULE_19]
		nxt_hb = hb_ff;
		if (wr_hb)
			nxt_hb = 1'b0; // [RULE_23]
		if (pin_rise[2])
			nxt_hb = 1'b1; // [RULE_22]
	end

	// request computed from next state so the pin lines up with the register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			exp_ff           <= ST_EXP_RESET; // [RULE_27]
			en_ff            <= ST_EN_RESET; // [RULE_27]
			out0_d_ff        <= 1'b1;
			out2_d_ff        <= 1'b1;
			timer_irq_line   <= 1'b0;
			timer_irq_periph <= 1'b0;
		end else if (ce) begin
			exp_ff    <= nxt_exp;
			en_ff     <= nxt_en;
			out0_d_ff <= out_ff[0];
			out2_d_ff <= out_ff[2];
			// [RULE_16] [RULE_15]
			timer_irq_line   <= (nxt_exp[ST_EXP0] & nxt_en[0]) | (nxt_exp[ST_EXP2] & nxt_en[1]);
			timer_irq_periph <= (nxt_exp[ST_EXP0] & nxt_en[0]) | (nxt_exp[ST_EXP2] & nxt_en[1]);
		end
	end

	// pins and heartbeat
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hb_ff               <= 1'b0;
			heartbeat_irq_input <= 1'b0;
			channel1_ext_out_n  <= 1'b0;
			channel2_ext_out_n  <= 1'b0;
			channel1_sys_irq    <= 1'b1;
		end else if (ce) begin
			hb_ff               <= nxt_hb;
			heartbeat_irq_input <= nxt_hb; // [RULE_22]
			channel1_ext_out_n  <= ~out_ff[1]; // [RULE_21]
			channel2_ext_out_n  <= ~out_ff[2]; // [RULE_21]
			channel1_sys_irq    <= out_ff[1]; // raw, not through status [RULE_20]
		end
	end

endmodule // itiu_top

/* File: src/itiu_pkg.sv */
// Purpose: shared constants for the interval timer and interrupt unit
// Assumes: bytewide io bus, 16-bit byte addresses
// Notes:   timer registers sit in the low byte of aligned longwords
package itiu_pkg;
	localparam logic [15:0] TIMER_BLOCK_BASE = 16'h4000;
	localparam logic [15:0] OFS_CH0_DATA     = 16'h0000;
	localparam logic [15:0] OFS_CH1_DATA     = 16'h0004;
	localparam logic [15:0] OFS_CH2_DATA     = 16'h0008;
	localparam logic [15:0] OFS_CONTROL      = 16'h000C;
	localparam logic [15:0] OFS_STATUS_PEEK  = 16'h0010;
	localparam logic [15:0] OFS_STATUS_CLEAR = 16'h0014;
	localparam logic [15:0] HEARTBEAT_CLEAR  = 16'h2000;
	// control byte fields
	localparam int CTL_SEL_HI  = 7;
	localparam int CTL_SEL_LO  = 6;
	localparam int CTL_ACC_HI  = 5;
	localparam int CTL_ACC_LO  = 4;
	localparam int CTL_MODE_HI = 3;
	localparam int CTL_MODE_LO = 1;
	localparam int CTL_BCD     = 0;
	localparam logic [1:0] SEL_STATUS_READ = 2'b11;
	// read-back command: bit 5 low latches count, bit 4 low latches status
	localparam int RB_NO_COUNT  = 5;
	localparam int RB_NO_STATUS = 4;
	// access modes
	localparam logic [1:0] ACC_LATCH = 2'b00;
	localparam logic [1:0] ACC_LSB   = 2'b01;
	localparam logic [1:0] ACC_MSB   = 2'b10;
	localparam logic [1:0] ACC_BOTH  = 2'b11;
	// counting modes
	localparam logic [2:0] MODE_ONESHOT_SW = 3'h0;
	localparam logic [2:0] MODE_ONESHOT_HW = 3'h1;
	localparam logic [2:0] MODE_SQUARE     = 3'h3;
	localparam logic [2:0] MODE_STROBE_HW  = 3'h5;
	// status register fields
	localparam int ST_EXP0 = 0;
	localparam int ST_EXP2 = 1;
	localparam int ST_EN0  = 4;
	localparam int ST_EN2  = 5;
	localparam logic [1:0] ST_EXP_RESET = 2'b00;
	localparam logic [1:0] ST_EN_RESET  = 2'b00;
	localparam logic [2:0] MODE_RESET   = 3'h0;
	localparam logic [1:0] ACC_RESET    = 2'b11;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	// timing
	localparam longint SYS_CLK_HZ  = 200000000;
	localparam longint CH_CLK_HZ   = 10000000;
	localparam int     CH_DIV      = int'(SYS_CLK_HZ / CH_CLK_HZ);
	localparam int     NUM_CH      = 3;
endpackage

/* File: test/itiu_top_props.sv */
// Purpose: port-level checks for the interval timer unit
// Assumes: sees only the top ports; enables mirrored from bus writes
// Notes:   channel 0 output is internal and nothing here checks it; status reads are checked for enables only
`timescale 1ns/1ps
module itiu_top_props
	import itiu_pkg::*;
#(
	parameter int DIV = CH_DIV
) (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        ce,
	input wire logic [15:0] bus_addr,
	input wire logic        bus_rd,
	input wire logic        bus_wr,
	input wire logic [7:0]  bus_wdata,
	input wire logic [7:0]  bus_rdata,
	input wire logic        ext_count_clock_n,
	input wire logic        ext_trigger_gate_n,
	input wire logic        heartbeat_wave,
	input wire logic        channel1_ext_out_n,
	input wire logic        channel2_ext_out_n,
	input wire logic        timer_irq_line,
	input wire logic        timer_irq_periph,
	input wire logic        channel1_sys_irq,
	input wire logic        heartbeat_irq_input
);
	localparam logic [15:0] PEEK = TIMER_BLOCK_BASE + OFS_STATUS_PEEK;
	localparam logic [15:0] CLR  = TIMER_BLOCK_BASE + OFS_STATUS_CLEAR;
	logic en0_ff;
	logic en2_ff;
	logic wr_ok;
	logic rd_ok;
	assign wr_ok = ce && bus_wr;
	assign rd_ok = ce && bus_rd;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// mirror of the enables: software can only toggle them, never write them
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			en0_ff <= 1'b0;
			en2_ff <= 1'b0;
		end else begin
			if (wr_ok && bus_addr == PEEK) en0_ff <= !en0_ff;
			if (wr_ok && bus_addr == CLR) en2_ff <= !en2_ff;
		end
	end
	sequence s_status_rd;
		rd_ok && (bus_addr == PEEK || bus_addr == CLR);
	endsequence
	sequence s_quiet_clear;
		!heartbeat_wave [*6] ##0 (wr_ok && bus_addr == HEARTBEAT_CLEAR);
	endsequence
	a_irq_both_ctrl: assert property (timer_irq_periph == timer_irq_line)
		else $error("timer request differs between controllers");
	a_irq_needs_en: assert property (!en0_ff && !en2_ff |-> !timer_irq_line)
		else $error("timer request with both enables off");
	a_status_read: assert property (s_status_rd |=> bus_rdata[7:4] ==
		{2'b00, $past(en2_ff), $past(en0_ff)} && bus_rdata[3:2] == 2'b00)
		else $error("status enables read back wrong");
	a_ch1_raw: assert property (channel1_sys_irq == !channel1_ext_out_n)
		else $error("channel 1 request not the raw output");
	a_reset_idle: assert property ($rose(reset_n) |-> !channel1_ext_out_n &&
		!channel2_ext_out_n && !timer_irq_line && !heartbeat_irq_input)
		else $error("outputs not idle after reset");
	a_hb_set: assert property ($rose(heartbeat_wave) |-> ##[1:8] heartbeat_irq_input)
		else $error("heartbeat edge not latched");
	a_hb_hold: assert property (heartbeat_irq_input &&
		!(wr_ok && bus_addr == HEARTBEAT_CLEAR) |=> heartbeat_irq_input)
		else $error("heartbeat request dropped without clear");
	a_hb_clear: assert property (s_quiet_clear |=> !heartbeat_irq_input)
		else $error("heartbeat request survived clear");
	a_rdata_hold: assert property (!rd_ok |=> $stable(bus_rdata))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (rd_ok &&
		!(bus_addr inside {[TIMER_BLOCK_BASE:CLR]}) |=> bus_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule // itiu_top_props

bind itiu_top itiu_top_props #(.DIV(DIV)) u_props (
	.clk(clk), .reset_n(reset_n), .ce(ce), .bus_addr(bus_addr), .bus_rd(bus_rd),
	.bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
	.ext_count_clock_n(ext_count_clock_n), .ext_trigger_gate_n(ext_trigger_gate_n),
	.heartbeat_wave(heartbeat_wave), .channel1_ext_out_n(channel1_ext_out_n),
	.channel2_ext_out_n(channel2_ext_out_n), .timer_irq_line(timer_irq_line),
	.timer_irq_periph(timer_irq_periph), .channel1_sys_irq(channel1_sys_irq),
	.heartbeat_irq_input(heartbeat_irq_input)
);

/* File: test/itiu_pins_model.sv */
// Purpose: board-side source for the channel 0 clock, gate and heartbeat pins
// Assumes: paced by the system clock; clock and gate pins idle high
// Notes:   the count clock stands still high while run is low
`timescale 1ns/1ps
module itiu_pins_model #(
	parameter int HALF = 40
) (
	input  wire logic clk,
	input  wire logic run,
	input  wire logic trig,
	input  wire logic hb,
	output logic      ext_count_clock_n = 1'b1,
	output logic      ext_trigger_gate_n,
	output logic      heartbeat_wave
);
	int cnt = 0;
	int gcnt = 0;
	// half period of 40 clocks gives 2.5 MHz, under the slow-clock limit
	always @(posedge clk) begin
		if (!run) begin
			cnt <= 0;
			ext_count_clock_n <= 1'b1;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			ext_count_clock_n <= !ext_count_clock_n;
		end else begin
			cnt <= cnt + 1;
		end
		if (trig) begin
			gcnt <= 6;
		end else if (gcnt > 0) begin
			gcnt <= gcnt - 1;
		end
	end
	assign ext_trigger_gate_n = (gcnt == 0);
	assign heartbeat_wave = hb;
endmodule // itiu_pins_model

/* File: test/interval_timer_irq_unit_tb_top.sv */
// Purpose: self-checking bench for the interval timer unit
// Assumes: channel 1/2 tick shortened to DIV=4; channel 0 clock from pin model
// Notes:   windows allow for tick phase and synchroniser lag
`timescale 1ns/1ps
module interval_timer_irq_unit_tb_top;
	import itiu_pkg::*;
	localparam int DV = 4;
	localparam int XT = 80;
	localparam logic [15:0] B = TIMER_BLOCK_BASE;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        ce = 1'b1;
	logic [15:0] bus_addr = 16'h0000;
	logic        bus_rd = 1'b0;
	logic        bus_wr = 1'b0;
	logic [7:0]  bus_wdata = 8'h00;
	logic        run = 1'b0;
	logic        trig = 1'b0;
	logic        hb = 1'b0;
	logic [7:0]  bus_rdata;
	logic        ext_count_clock_n, ext_trigger_gate_n, heartbeat_wave;
	logic        channel1_ext_out_n, channel2_ext_out_n, timer_irq_line;
	logic        timer_irq_periph, channel1_sys_irq, heartbeat_irq_input;
	int          mismatches = 0;
	int          compares = 0;
	itiu_top #(.DIV(DV)) DUT (.clk(clk), .reset_n(reset_n), .ce(ce),
		.bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata), .ext_count_clock_n(ext_count_clock_n),
		.ext_trigger_gate_n(ext_trigger_gate_n), .heartbeat_wave(heartbeat_wave),
		.channel1_ext_out_n(channel1_ext_out_n), .channel2_ext_out_n(channel2_ext_out_n),
		.timer_irq_line(timer_irq_line), .timer_irq_periph(timer_irq_periph),
		.channel1_sys_irq(channel1_sys_irq), .heartbeat_irq_input(heartbeat_irq_input));
	itiu_pins_model #(.HALF(XT / 2)) u_pins (.clk(clk), .run(run), .trig(trig), .hb(hb),
		.ext_count_clock_n(ext_count_clock_n), .ext_trigger_gate_n(ext_trigger_gate_n),
		.heartbeat_wave(heartbeat_wave));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic span(input int got, input int lo, input int hi);
		compares++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("Error %0t: %0d cycles, want %0d..%0d", $time, got, lo, hi);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge clk);
		bus_wr = 1'b0;
	endtask
	// low byte then high byte, as the access mode 11 pointer expects
	task automatic wcnt(input logic [15:0] a, input logic [7:0] lo);
		wr(a, lo);
		wr(a, 8'h00);
	endtask
	task automatic rdc(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
		@(negedge clk);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge clk);
		bus_rd = 1'b0;
		@(negedge clk);
		chk(bus_rdata & m, e);
	endtask
	// counts cycles while the selected output keeps level v, bounded
	task automatic hold(input int s, input logic v, output int c);
		logic p[3];
		c = 0;
		p = '{channel1_ext_out_n, channel2_ext_out_n, timer_irq_line};
		while (p[s] === v && c < 600) begin
			@(negedge clk);
			c++;
			p = '{channel1_ext_out_n, channel2_ext_out_n, timer_irq_line};
		end
	endtask
	task automatic t_status();
		rdc(B + OFS_STATUS_PEEK, 8'hFF, 8'h00);
		chk(timer_irq_line, 8'h00);
		wr(B + OFS_STATUS_PEEK, 8'hFF);
		rdc(B + OFS_STATUS_PEEK, 8'hFF, 8'h10);
		wr(B + OFS_STATUS_CLEAR, 8'h00);
		rdc(B + OFS_STATUS_CLEAR, 8'hFF, 8'h30);
		ce = 1'b0;
		wr(B + OFS_STATUS_PEEK, 8'h00);
		ce = 1'b1;
		rdc(B + OFS_STATUS_PEEK, 8'hFF, 8'h30);
		rdc(B + 16'h0018, 8'hFF, 8'h00);
	endtask
	task automatic t_mode0(input int n1, input int n2);
		int c;
		int nn;
		nn = (n2 > 0) ? n2 : n1;
		wr(B + OFS_CONTROL, 8'hB0);
		@(negedge clk);
		chk(channel2_ext_out_n, 8'h00);
		wcnt(B + OFS_CH2_DATA, n1[7:0]);
		if (n2 > 0) begin
			repeat (2 * DV) @(negedge clk);
			wcnt(B + OFS_CH2_DATA, n2[7:0]);
		end
		@(negedge clk);
		chk(channel2_ext_out_n, 8'h01);
		hold(1, 1'b1, c);
		span(c, nn * DV - 2, (nn + 1) * DV + 2);
		repeat (2) @(negedge clk);
		chk(timer_irq_line, 8'h01);
		rdc(B + OFS_STATUS_PEEK, 8'hFF, 8'h32);
		rdc(B + OFS_STATUS_CLEAR, 8'hFF, 8'h32);
		rdc(B + OFS_STATUS_PEEK, 8'hFF, 8'h30);
		chk(timer_irq_line, 8'h00);
	endtask
	task automatic t_square();
		int c;
		int hi;
		int lo;
		wr(B + OFS_CONTROL, 8'h76);
		wcnt(B + OFS_CH1_DATA, 8'h05);
		repeat (4 * DV) @(negedge clk);
		hold(0, 1'b1, c);
		hold(0, 1'b0, c);
		hold(0, 1'b1, lo);
		hold(0, 1'b0, hi);
		span(hi, 3 * DV, 3 * DV);
		span(lo, 2 * DV, 2 * DV);
		wr(B + OFS_CONTROL, 8'hE4);
		rdc(B + OFS_CH1_DATA, 8'h3F, 8'h36);
	endtask
	task automatic t_ch0(input logic [7:0] ctl, input int extra);
		int c;
		rdc(B + OFS_STATUS_CLEAR, 8'hFF, 8'h30);
		run = 1'b1;
		wr(B + OFS_CONTROL, ctl);
		wcnt(B + OFS_CH0_DATA, 8'h02);
		repeat (4 * XT) @(negedge clk);
		rdc(B + OFS_STATUS_PEEK, 8'hFF, 8'h30);
		trig = 1'b1;
		@(negedge clk);
		trig = 1'b0;
		hold(2, 1'b0, c);
		span(c, (2 + extra) * XT - 2, (3 + extra) * XT + 20);
		rdc(B + OFS_STATUS_CLEAR, 8'hFF, 8'h31);
		run = 1'b0;
	endtask
	task automatic t_heart();
		hb = 1'b1;
		repeat (8) @(negedge clk);
		chk(heartbeat_irq_input, 8'h01);
		hb = 1'b0;
		repeat (8) @(negedge clk);
		rdc(HEARTBEAT_CLEAR, 8'hFF, 8'h00);
		chk(heartbeat_irq_input, 8'h01);
		wr(HEARTBEAT_CLEAR, 8'h00);
		repeat (2) @(negedge clk);
		chk(heartbeat_irq_input, 8'h00);
	endtask
	task automatic test_done();
		if (mismatches == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		t_status();
		t_mode0(3, 0);
		t_mode0(3, 8);
		t_square();
		t_ch0(8'h32, 0);
		t_ch0(8'h3A, 1);
		t_heart();
		test_done();
	end
	// whole run needs about 1500 cycles
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		test_done();
	end
endmodule // interval_timer_irq_unit_tb_top
